// *** rtl/sespi_dev.sv ***
// Device end: serial target timed by the host clock
`timescale 1ns/1ps
module sespi_dev (
  input wire logic ref_clk,
  input wire logic reset,
  sespi_link_if.dev link,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_load,
  input wire logic [7:0] tx_data,
  input wire logic resp_ready,
  output logic ext_rst_n
);
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic tog_q;
  logic [7:0] out_q;
  logic miso_q;
  logic [7:0] txh_q;
  logic tx_tog_q;
  logic txa_q;
  logic txb_q;
  logic irq_q;
  logic txc_q;
  logic took_q;
  logic tog_s;
  logic tog_d_q;
  logic [7:0] rxo_q;
  logic sel_s;
  logic sel_d_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shifting uses only the serial clock; sense pad unused
  always_ff @(posedge link.sclk or posedge link.sel_n)
  begin
    if (link.sel_n)
      bit_q <= 3'h0;
    else
      bit_q <= bit_q + 3'h1;
  end

  // Reset is asynchronous here: the serial clock stands still during reset
  always_ff @(posedge link.sclk or posedge reset)
  begin
    if (reset)
    begin
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      tog_q <= 1'b0;
    end
    else
    begin
      sh_q <= {sh_q[6:0], link.mosi};
      if (bit_q == sespi_pkg::SESPI_BIT_LAST)
      begin
        rx_q <= {sh_q[6:0], link.mosi};
        tog_q <= ~tog_q;
      end
    end
  end

  // Reply byte taken from held word; it is stable while toggle settles
  always_ff @(posedge link.sclk or posedge reset)
  begin
    if (reset)
    begin
      txa_q <= 1'b0;
      txb_q <= 1'b0;
      txc_q <= 1'b0;
    end
    else
    begin
      txa_q <= tx_tog_q;
      txb_q <= txa_q;
      // Consumed only once the next byte starts, so a frame that ends at
      // the byte boundary keeps the reply for the following frame
      if (bit_q == 3'h0 && took_q)
        txc_q <= ~txc_q;
    end
  end

  always_ff @(posedge link.sclk or posedge link.sel_n)
  begin
    if (link.sel_n)
      took_q <= 1'b0;
    else if (bit_q == sespi_pkg::SESPI_BIT_LAST)
      took_q <= txb_q != txc_q;
  end

  // First byte of a frame is always the idle byte
  always_ff @(posedge link.sclk or posedge link.sel_n)
  begin
    if (link.sel_n)
      out_q <= sespi_pkg::SESPI_IDLE_BYTE;
    else if (bit_q == sespi_pkg::SESPI_BIT_LAST)
      out_q <= (txb_q != txc_q) ? txh_q : sespi_pkg::SESPI_IDLE_BYTE;
    else
      out_q <= {out_q[6:0], 1'b1};
  end

  // Change data on falling edge, host samples on rising
  always_ff @(negedge link.sclk or posedge link.sel_n)
  begin
    if (link.sel_n)
      miso_q <= 1'b1;
    else
      miso_q <= out_q[7];
  end

  ////////////////////////////////////////////////////////////////////////////
  sespi_sync u_tog (.clk(ref_clk), .reset(reset), .din(tog_q), .dout(tog_s));
  sespi_sync u_sel (.clk(ref_clk), .reset(reset), .din(link.sel_n),
    .dout(sel_s));
  sespi_sync u_rst (.clk(ref_clk), .reset(reset), .din(link.rst_n),
    .dout(ext_rst_n));

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tog_d_q <= 1'b0;
      // Same as the synchroniser's reset value, so no false select fall
      sel_d_q <= 1'b0;
      rxo_q <= 8'h00;
    end
    else
    begin
      tog_d_q <= tog_s;
      sel_d_q <= sel_s;
      if (tog_s != tog_d_q)
        rxo_q <= rx_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      txh_q <= sespi_pkg::SESPI_IDLE_BYTE;
      tx_tog_q <= 1'b0;
    end
    else if (tx_load)
    begin
      txh_q <= tx_data;
      tx_tog_q <= ~tx_tog_q;
    end
  end

  // Ready edge on new response; drops when host selects to fetch
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      irq_q <= 1'b0;
    else if (resp_ready && !irq_q)
      irq_q <= 1'b1;
    else if (sel_d_q && !sel_s)
      irq_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rx_valid <= 1'b0;
    else
      rx_valid <= tog_s != tog_d_q;
  end

  assign rx_data = rxo_q;
  assign link.miso = miso_q;
  assign link.ready_irq = irq_q;
endmodule : sespi_dev

// *** rtl/sespi_host.sv ***
// Host end: serial master that exchanges one byte per request
`timescale 1ns/1ps
module sespi_host (
  input wire logic ref_clk,
  input wire logic reset,
  sespi_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  input wire logic dev_rst_n,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_pending
);
  typedef enum logic [1:0] {SESPI_IDLE, SESPI_LOW, SESPI_HIGH} sespi_hst_t;
  sespi_hst_t st_q;
  logic [7:0] div_q;
  logic [2:0] bit_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic last_q;
  logic sclk_q;
  logic sel_n_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic miso_s;
  logic irq_s;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  sespi_sync u_miso (.clk(ref_clk), .reset(reset), .din(link.miso),
    .dout(miso_s));
  sespi_sync u_irq (.clk(ref_clk), .reset(reset), .din(link.ready_irq),
    .dout(irq_s));

  assign tick = (div_q == sespi_pkg::SESPI_HALF_CNT - 8'h01);
  assign req_ready = (st_q == SESPI_IDLE) || (st_q == SESPI_HIGH && tick &&
    bit_q == sespi_pkg::SESPI_BIT_LAST && !last_q);

  // Half period never shorter than the link limit allows
  always_ff @(posedge ref_clk)
  begin
    if (reset || st_q == SESPI_IDLE || tick)
      div_q <= sespi_pkg::SESPI_CNT_RESET;
    else
      div_q <= div_q + 8'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      st_q <= SESPI_IDLE;
    else
    begin
      unique case (st_q)
        SESPI_IDLE:
          if (req_valid)
            st_q <= SESPI_LOW;
        SESPI_LOW:
          if (tick)
            st_q <= SESPI_HIGH;
        SESPI_HIGH:
          if (tick && bit_q == sespi_pkg::SESPI_BIT_LAST)
            st_q <= (last_q || !req_valid) ? SESPI_IDLE : SESPI_LOW;
          else if (tick)
            st_q <= SESPI_LOW;
      endcase
    end
  end

  // Frame: select held low across bytes of one unit; a byte end with req_valid low closes it early
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      sel_n_q <= 1'b1;
    else if (st_q == SESPI_IDLE && req_valid)
      sel_n_q <= 1'b0;
    else if (st_q == SESPI_HIGH && tick && bit_q == sespi_pkg::SESPI_BIT_LAST
      && (last_q || !req_valid))
      sel_n_q <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      sclk_q <= 1'b0;
    else if (st_q == SESPI_LOW && tick)
      sclk_q <= 1'b1;
    else if (st_q == SESPI_HIGH && tick)
      sclk_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tx_q <= sespi_pkg::SESPI_IDLE_BYTE;
      last_q <= 1'b0;
      bit_q <= 3'h0;
    end
    else if (req_valid && req_ready)
    begin
      tx_q <= req_data;
      last_q <= req_last;
      bit_q <= 3'h0;
    end
    else if (st_q == SESPI_HIGH && tick)
    begin
      tx_q <= {tx_q[6:0], 1'b1};
      bit_q <= bit_q + 3'h1;
    end
  end

  // Sample on rising edge; synchroniser delay fits in the half period
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rx_q <= 8'h00;
    else if (st_q == SESPI_LOW && tick)
      rx_q <= {rx_q[6:0], miso_s};
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
    end
    else
    begin
      rsp_valid_q <= st_q == SESPI_HIGH && tick &&
        bit_q == sespi_pkg::SESPI_BIT_LAST;
      if (st_q == SESPI_HIGH && tick && bit_q == sespi_pkg::SESPI_BIT_LAST)
        rsp_data_q <= rx_q;
    end
  end

  assign link.sclk = sclk_q;
  assign link.sel_n = sel_n_q;
  assign link.mosi = tx_q[7];
  assign link.rst_n = dev_rst_n;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_pending = irq_s;
endmodule : sespi_host

// *** rtl/sespi_link_if.sv ***
// Serial link pins between host and secure element
`timescale 1ns/1ps
interface sespi_link_if;
  logic sclk;
  logic sel_n;
  logic mosi;
  logic miso;
  logic ready_irq;
  logic rst_n;
  logic sense_sel;
  modport host (
    output sclk,
    output sel_n,
    output mosi,
    input miso,
    input ready_irq,
    output rst_n
  );
  modport dev (
    input sclk,
    input sel_n,
    input mosi,
    output miso,
    output ready_irq,
    input rst_n,
    input sense_sel
  );
  // Sense pad is bonded to the select pad
  assign sense_sel = sel_n;
endinterface : sespi_link_if

// *** rtl/sespi_pkg.sv ***
// Shared constants and types for the secure element serial host port
package sespi_pkg;
  localparam int SESPI_DATA_W = 8;
  localparam int SESPI_BIT_CNT_W = 3;
  localparam logic [2:0] SESPI_BIT_LAST = 3'h7;
  localparam logic [7:0] SESPI_IDLE_BYTE = 8'hFF;
  // Serial clock limit and the reference clock rate
  localparam int SESPI_LINK_MAX_KHZ = 10000;
  localparam int SESPI_REF_KHZ = 10000;
  // Reference cycles per half link period, rounded up
  localparam int SESPI_HALF_RAW = (SESPI_REF_KHZ + 2 * SESPI_LINK_MAX_KHZ - 1)
    / (2 * SESPI_LINK_MAX_KHZ);
  // Returned data passes two flip-flops in the host, so three reference
  // cycles per half period is the least that samples the current bit
  localparam int SESPI_HALF_MIN = 3;
  localparam int SESPI_HALF_CYC = (SESPI_HALF_RAW < SESPI_HALF_MIN) ?
    SESPI_HALF_MIN : SESPI_HALF_RAW;
  localparam logic [7:0] SESPI_HALF_CNT = 8'(SESPI_HALF_CYC);
  localparam logic [7:0] SESPI_CNT_RESET = 8'h00;
  localparam logic [1:0] SESPI_SYNC_RESET = 2'h0;
  typedef logic [SESPI_DATA_W-1:0] sespi_byte_t;
endpackage : sespi_pkg

// *** rtl/sespi_sync.sv ***
// Two-stage level synchroniser
`timescale 1ns/1ps
module sespi_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  logic [1:0] sync_q;
  always_ff @(posedge clk)
  begin
    if (reset)
      sync_q <= sespi_pkg::SESPI_SYNC_RESET;
    else
      sync_q <= {sync_q[0], din};
  end
  assign dout = sync_q[1];
endmodule : sespi_sync

// *** testbench/secure_element_spi_host_port_tb_top.sv ***
// Bench joining host end and device end over the serial link
`timescale 1ns/1ps
module secure_element_spi_host_port_tb_top;
  logic ref_clk, reset, req_valid, req_ready, req_last, dev_rst_n;
  logic rsp_valid, rsp_pending, rx_valid, tx_load, resp_ready, ext_rst_n;
  sespi_pkg::sespi_byte_t req_data, rsp_data, rx_data, tx_data, wire_q;
  logic [7:0] rx_q[$];
  logic [7:0] rsp_q[$];
  int mismatches, check_count;
  sespi_link_if link ();
  sespi_host u_sespi_host (.ref_clk(ref_clk), .reset(reset), .link(link),
    .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
    .req_last(req_last), .dev_rst_n(dev_rst_n), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_pending(rsp_pending));
  sespi_dev u_sespi_dev (.ref_clk(ref_clk), .reset(reset), .link(link),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_load(tx_load),
    .tx_data(tx_data), .resp_ready(resp_ready), .ext_rst_n(ext_rst_n));
  sespi_checker u_sespi_checker (.ref_clk(ref_clk), .reset(reset),
    .sclk(link.sclk), .sel_n(link.sel_n), .mosi(link.mosi),
    .miso(link.miso), .ready_irq(link.ready_irq), .rst_n(link.rst_n),
    .sense_sel(link.sense_sel));
  ////////////////////////////////
  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // Called at a clock edge; returns at the accepting edge so bytes chain
  task send(input logic [7:0] d, input logic last);
    int n;
    #1 req_valid = 1'h1;
    req_data = d;
    req_last = last;
    n = 0;
    do
      @(posedge ref_clk) n++;
    while (req_ready !== 1'h1 && n < 100);
    check("accept", 8'h01, req_ready);
    if (last)
      #1 req_valid = 1'h0;
  endtask : send
  task wait_bytes(input int n);
    for (int k = 0; k < 100 && (rx_q.size() < n || rsp_q.size() < n); k++)
      @(posedge ref_clk);
  endtask : wait_bytes
  ////////////////////////////////
  always @(posedge ref_clk)
  begin
    if (rx_valid)
      rx_q.push_back(rx_data);
    if (rsp_valid)
      rsp_q.push_back(rsp_data);
  end
  // Device samples mosi on the leading edge, so the wire is read there too
  always @(posedge link.sclk)
    wire_q <= {wire_q[6:0], link.mosi};
  initial
  begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    #200000;
    mismatches++;
    $display("MISMATCH watchdog expected 00 seen 01");
    finish_test();
  end
  initial
  begin
    int k;
    reset = 1'h0;
    req_valid = 1'h0;
    req_data = 8'h00;
    req_last = 1'h0;
    dev_rst_n = 1'h1;
    tx_load = 1'h0;
    tx_data = 8'h00;
    resp_ready = 1'h0;
    // Raised after time zero so every asynchronous reset sees the edge
    #1 reset = 1'h1;
    repeat (6) @(posedge ref_clk);
    #1 reset = 1'h0;
    @(posedge ref_clk);
    check("sel_n", 8'h01, link.sel_n);
    check("sclk", 8'h00, link.sclk);
    check("ready", 8'h00, link.ready_irq);
    send(8'hA5, 1'h1);
    wait_bytes(1);
    check("rx", 8'hA5, rx_q.pop_front());
    check("rsp", sespi_pkg::SESPI_IDLE_BYTE, rsp_q.pop_front());
    check("wire", 8'hA5, wire_q);
    @(posedge ref_clk);
    #1 tx_load = 1'h1;
    tx_data = 8'h3C;
    @(posedge ref_clk);
    #1 tx_load = 1'h0;
    @(posedge ref_clk);
    send(8'h12, 1'h0);
    send(8'h34, 1'h1);
    wait_bytes(2);
    check("rx0", 8'h12, rx_q.pop_front());
    check("rx1", 8'h34, rx_q.pop_front());
    check("rsp0", sespi_pkg::SESPI_IDLE_BYTE, rsp_q.pop_front());
    check("rsp1", 8'h3C, rsp_q.pop_front());
    @(posedge ref_clk);
    #1 resp_ready = 1'h1;
    @(posedge ref_clk);
    #1 resp_ready = 1'h0;
    for (k = 0; k < 20 && rsp_pending !== 1'h1; k++)
      @(posedge ref_clk);
    repeat (10) @(posedge ref_clk);
    check("pending", 8'h01, rsp_pending);
    send(8'h5A, 1'h1);
    wait_bytes(1);
    check("rx2", 8'h5A, rx_q.pop_front());
    check("rsp2", sespi_pkg::SESPI_IDLE_BYTE, rsp_q.pop_front());
    repeat (4) @(posedge ref_clk);
    check("cleared", 8'h00, rsp_pending);
    #1 dev_rst_n = 1'h0;
    repeat (5) @(posedge ref_clk);
    check("rst_low", 8'h00, ext_rst_n);
    #1 dev_rst_n = 1'h1;
    repeat (5) @(posedge ref_clk);
    check("rst_high", 8'h01, ext_rst_n);
    finish_test();
  end
endmodule : secure_element_spi_host_port_tb_top

// *** testbench/sespi_checker.sv ***
// Link protocol checks for the secure element serial port
`timescale 1ns/1ps
module sespi_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic ready_irq,
  input wire logic rst_n,
  input wire logic sense_sel
);
  logic sclk_q;
  logic [2:0] bits_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////
  always_ff @(posedge ref_clk)
    sclk_q <= sclk;
  // Rising clock edges in the frame, modulo one byte
  always_ff @(posedge ref_clk)
    if (reset || sel_n)
      bits_q <= 3'h0;
    else if (sclk && !sclk_q)
      bits_q <= bits_q + 3'h1;
  ////////////////////////////////
  chk_idle_clk_low:
  assert property (sel_n |-> !sclk) else $error("clock runs unselected");
  chk_half_period:
  assert property ($rose(sclk) |-> sclk[*3] ##1 !sclk)
    else $error("clock high time");
  chk_low_period:
  assert property ($fell(sclk) && !sel_n |-> !sclk[*3] ##1 sclk)
    else $error("clock low time");
  chk_select_idle:
  assert property ($fell(reset) |-> sel_n) else $error("select low at reset");
  chk_sense_link:
  assert property (sense_sel == sel_n) else $error("sense differs");
  chk_mosi_setup:
  assert property ($rose(sclk) |-> $stable(mosi)) else $error("mosi moved");
  chk_miso_setup:
  assert property ($rose(sclk) |-> $stable(miso)) else $error("miso moved");
  chk_whole_bytes:
  assert property ($rose(sel_n) |-> bits_q == 3'h0) else $error("part byte");
  chk_ready_hold:
  assert property (ready_irq && sel_n |=> ready_irq) else $error("ready lost");
  chk_ready_drop:
  assert property ($fell(sel_n) && ready_irq |-> ##[1:6] !ready_irq)
    else $error("ready kept");
endmodule : sespi_checker
